// ### rtl/nvw_consts.vh
/*
  nvw_consts.vh: register addresses, codes, field positions and timing counts
  for the run-time flash / eeprom write controller.
  assumes: included by bare name from rtl files; core clock 25 MHz.
*/
`ifndef NVW_CONSTS_VH
`define NVW_CONSTS_VH

// special function register addresses
`define NVW_ADDR_SOFTWARE_COMMAND       8'h97
`define NVW_ADDR_WRITE_ENABLE_COMMAND   8'hC9
`define NVW_ADDR_RESET_POWERDOWN        8'hE5
`define NVW_ADDR_AUX_CONTROL_TWO        8'hF7

// command codes
`define NVW_CODE_FLASH_ENABLE           8'h47
`define NVW_CODE_EEPROM_ENABLE          8'hE2
`define NVW_CODE_FULL_RANGE             8'h65
`define NVW_CODE_FREE_RANGE             8'h00
`define NVW_CODE_SOFT_RESET             8'h56
`define NVW_CODE_RESETS_OFF             8'h37
`define NVW_CODE_VOLT_RESET_OFF         8'h38

// field positions
`define NVW_BIT_FLASH_WE                7
`define NVW_BIT_TIMEOUT                 6
`define NVW_BIT_EEPROM_WE               5
`define NVW_BIT_FULL_RANGE              0
`define NVW_BIT_TSEL_HI                 2
`define NVW_BIT_TSEL_LO                 1
`define NVW_AUXILIARY_CONTROL_TWO_RESET                  8'h06

// address map
`define NVW_FLASH_WRITE_MAX             16'h1FFE
`define NVW_FLASH_FULL_MAX              16'h1FEF
`define NVW_FLASH_FREE_MIN              16'h1F00
`define NVW_EEPROM_BASE_HI              8'hEE

// timing: 20 bit operands so cycle products stay 20 bits wide
`define NVW_CLK_MHZ                     20'h00019
`define NVW_FLASH_WRITE_US              20'h001F4
`define NVW_EEPROM_WRITE_US             20'h003E8
`define NVW_TO1_US                      20'h00640
`define NVW_TO2_US                      20'h00C80
`define NVW_TO3_US                      20'h03200
`define NVW_EEPROM_READ_NS              20'h0012C
`define NVW_EEPROM_READ_CYC             ((`NVW_EEPROM_READ_NS * `NVW_CLK_MHZ) / 20'h003E8)

`endif

// ### rtl/nvw_eeprom_array.v
/*
  nvw_eeprom_array.v: 128 byte eeprom cell array with registered read data.
  assumes: writes and reads come from the controller on the same clock.
*/
`default_nettype none

module nvw_eeprom_array (
  // clock
  input  wire       clk,
  // write port
  input  wire       wr_en,
  input  wire [6:0] wr_index,
  input  wire [7:0] wr_data,
  // read port
  input  wire [6:0] rd_index,
  output reg  [7:0] rd_data
);

  reg [7:0] cells [0:127];

  // no reset: cell contents are nonvolatile by intent
  always @(posedge clk) begin
    if (wr_en) begin
      cells[wr_index] <= wr_data;
    end
    rd_data <= cells[rd_index];
  end

endmodule

`default_nettype wire

// ### rtl/nvw_ctrl.v
/*
  nvw_ctrl.v: run-time flash and eeprom write controller with its command
  registers (software command, write enable, reset power-down, aux control two).
  assumes: the cpu core presents one sfr access per strobe, external-data moves
  as one-cycle strobes, and holds while cpu_wait is high; the flash macro takes
  a one-cycle program strobe and reports done; all on core_clk.
*/
//
// Contract
// - flash store via data pointer, 0000h-1FFEh; code programs only up to 1FEFh
// - flash program only with flash enable
// - stall cpu for whole flash write
// - peripherals run, interrupts stay pending
// - code reads add no wait cycles
// - 47h/E2h set enables, else clear both
// - bit 7 reads flash enable
// - bit 5 reads eeprom enable
// - timeout flag set, cleared with enable
// - select field picks timeout, abandons write
// - 65h widens range, 00h restricts
// - bit 0 low refuses low region
// - eeprom even addresses only, odd ignored
// - eeprom store stalls cpu while writing
// - eeprom shares timeout counter and flag
// - eeprom load returns within 300 ns
// - 37h/38h power down reset sources
// - 56h triggers software reset
// - byte writes, no page erase
`default_nettype none
`include "nvw_consts.vh"

module nvw_ctrl #(
  parameter [19:0] FLASH_WRITE_CYC  = `NVW_FLASH_WRITE_US * `NVW_CLK_MHZ,
  parameter [19:0] EEPROM_WRITE_CYC = `NVW_EEPROM_WRITE_US * `NVW_CLK_MHZ,
  parameter [19:0] TO1_CYC          = `NVW_TO1_US * `NVW_CLK_MHZ,
  parameter [19:0] TO2_CYC          = `NVW_TO2_US * `NVW_CLK_MHZ,
  parameter [19:0] TO3_CYC          = `NVW_TO3_US * `NVW_CLK_MHZ
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // sfr access from cpu
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  // external-data moves from cpu
  input  wire        xdata_wr,
  input  wire        xdata_rd,
  input  wire [15:0] xdata_addr,
  input  wire [7:0]  xdata_wdata,
  output reg  [7:0]  xdata_rdata,
  output reg         xdata_rvalid,
  // cpu stall
  output wire        cpu_wait,
  // flash macro program port
  output reg         flash_prog,
  output reg  [12:0] flash_prog_addr,
  output reg  [7:0]  flash_prog_data,
  input  wire        flash_prog_done,
  // code reads pass straight through
  input  wire        code_rd,
  output wire        code_wait,
  // reset controls
  output reg         soft_reset_command,
  output reg         low_voltage_reset_off,
  output reg         power_on_reset_off
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  reg rst_meta;
  reg rst_sync;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function is_eeprom_even;
    input [15:0] a;
    begin
      is_eeprom_even = (a[15:8] == `NVW_EEPROM_BASE_HI) && !a[0];
    end
  endfunction

  function flash_permitted;
    input [15:0] a;
    input        full;
    begin
      if (full)
        flash_permitted = (a <= `NVW_FLASH_FULL_MAX);
      else
        flash_permitted = (a >= `NVW_FLASH_FREE_MIN) && (a <= `NVW_FLASH_FULL_MAX);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_FLASH  = 3'b010;
  localparam [2:0] ST_EEPROM = 3'b100;

  reg        flash_write_enable;
  reg        eeprom_write_enable;
  reg        write_timeout_flag;
  reg        full_range_unlock;
  reg        watchdog_overflow_flag;
  reg [7:0]  auxiliary_control_two;
  reg [2:0]  state;
  reg [19:0] busy_cnt;
  reg [19:0] to_cnt;
  reg [19:0] to_limit;
  reg [6:0]  ee_wr_index;
  reg [7:0]  ee_wr_data;
  reg        ee_wr_en;
  // array addressed straight from the bus so the byte is ready for the answer
  wire [6:0] ee_rd_index = xdata_addr[7:1];
  reg        ee_rd_pend;
  wire [7:0] ee_rd_data;

  wire [1:0] timeout_select = auxiliary_control_two[`NVW_BIT_TSEL_HI:`NVW_BIT_TSEL_LO];
  wire       sel_we  = sfr_wr && (sfr_addr == `NVW_ADDR_WRITE_ENABLE_COMMAND);
  wire       sel_sw  = sfr_wr && (sfr_addr == `NVW_ADDR_SOFTWARE_COMMAND);
  wire       sel_pd  = sfr_wr && (sfr_addr == `NVW_ADDR_RESET_POWERDOWN);
  wire       sel_ax  = sfr_wr && (sfr_addr == `NVW_ADDR_AUX_CONTROL_TWO);
  // enables as they stand after this edge; the timeout flag clears with them
  wire       next_flash_write_enable  = sel_we ? (sfr_wdata == `NVW_CODE_FLASH_ENABLE) :
                                        flash_write_enable;
  wire       next_eeprom_write_enable = sel_we ? (sfr_wdata == `NVW_CODE_EEPROM_ENABLE) :
                                        eeprom_write_enable;
  wire       idle    = (state == ST_IDLE);

  // accepted write starts; anything else completes at once without stall
  wire start_flash = idle && xdata_wr && flash_write_enable &&
                     (xdata_addr <= `NVW_FLASH_WRITE_MAX) &&
                     flash_permitted(xdata_addr, full_range_unlock);
  wire start_ee    = idle && xdata_wr && eeprom_write_enable &&
                     is_eeprom_even(xdata_addr);
  wire to_hit      = !idle && (timeout_select != 2'b00) && (to_cnt >= to_limit);

  // stall only while a write is running; the core freezes, peripherals do not
  assign cpu_wait  = !idle;
  assign code_wait = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // write state machine

  reg [2:0]  next_state;
  reg [19:0] next_busy_cnt;

  always @* begin
    next_state    = state;
    next_busy_cnt = busy_cnt;
    case (state)
      ST_IDLE: begin
        if (start_flash) begin
          next_state    = ST_FLASH;
          next_busy_cnt = 20'h00000;
        end else if (start_ee) begin
          next_state    = ST_EEPROM;
          next_busy_cnt = 20'h00000;
        end
      end
      ST_FLASH: begin
        next_busy_cnt = busy_cnt + 20'h00001;
        // a done from the macro ends the stall; a late macro is escaped by timeout
        if (to_hit || flash_prog_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_EEPROM: begin
        next_busy_cnt = busy_cnt + 20'h00001;
        if (to_hit || (busy_cnt >= EEPROM_WRITE_CYC - 20'h00001)) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state           <= ST_IDLE;
      busy_cnt        <= 20'h00000;
      to_cnt          <= 20'h00000;
      to_limit        <= 20'h00000;
      flash_prog      <= 1'b0;
      flash_prog_addr <= 13'h0000;
      flash_prog_data <= 8'h00;
      ee_wr_en        <= 1'b0;
      ee_wr_index     <= 7'h00;
      ee_wr_data      <= 8'h00;
    end else begin
      state      <= next_state;
      busy_cnt   <= next_busy_cnt;
      flash_prog <= start_flash;
      ee_wr_en   <= 1'b0;
      if (idle) begin
        to_cnt <= 20'h00000;
        case (timeout_select)
          2'b01:   to_limit <= TO1_CYC;
          2'b10:   to_limit <= TO2_CYC;
          default: to_limit <= TO3_CYC;
        endcase
      end else begin
        to_cnt <= to_cnt + 20'h00001;
      end
      if (start_flash) begin
        flash_prog_addr <= xdata_addr[12:0];
        flash_prog_data <= xdata_wdata;
      end
      if (start_ee) begin
        ee_wr_index <= xdata_addr[7:1];
        ee_wr_data  <= xdata_wdata;
      end
      // cell is committed at the end of the write time, not on timeout
      if ((state == ST_EEPROM) && !to_hit &&
          (busy_cnt >= EEPROM_WRITE_CYC - 20'h00001)) begin
        ee_wr_en <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command registers

  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      flash_write_enable     <= 1'b0;
      eeprom_write_enable    <= 1'b0;
      write_timeout_flag     <= 1'b0;
      full_range_unlock      <= 1'b0;
      watchdog_overflow_flag <= 1'b0;
      auxiliary_control_two  <= `NVW_AUXILIARY_CONTROL_TWO_RESET;
      soft_reset_command     <= 1'b0;
      low_voltage_reset_off  <= 1'b0;
      power_on_reset_off     <= 1'b0;
    end else begin
      soft_reset_command <= sel_sw && (sfr_wdata == `NVW_CODE_SOFT_RESET);
      flash_write_enable  <= next_flash_write_enable;
      eeprom_write_enable <= next_eeprom_write_enable;
      if (sel_sw && (sfr_wdata != `NVW_CODE_SOFT_RESET)) begin
        // only 65h unlocks; 00h and other non-reset codes lock
        full_range_unlock <= (sfr_wdata == `NVW_CODE_FULL_RANGE);
      end
      if (sel_ax) begin
        auxiliary_control_two <= sfr_wdata;
      end
      if (sel_pd) begin
        low_voltage_reset_off <= (sfr_wdata == `NVW_CODE_RESETS_OFF) ||
                                 (sfr_wdata == `NVW_CODE_VOLT_RESET_OFF);
        power_on_reset_off    <= (sfr_wdata == `NVW_CODE_RESETS_OFF);
      end
      // set wins over the clear that comes with a zero enable
      if (to_hit) begin
        write_timeout_flag <= 1'b1;
      end else if (!next_flash_write_enable && !next_eeprom_write_enable) begin
        write_timeout_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sfr read mux

  always @* begin
    sfr_rdata = 8'h00;
    case (sfr_addr)
      `NVW_ADDR_WRITE_ENABLE_COMMAND: begin
        sfr_rdata[`NVW_BIT_FLASH_WE]  = flash_write_enable;
        sfr_rdata[`NVW_BIT_TIMEOUT]   = write_timeout_flag;
        sfr_rdata[`NVW_BIT_EEPROM_WE] = eeprom_write_enable;
      end
      `NVW_ADDR_SOFTWARE_COMMAND: begin
        sfr_rdata[1]                   = watchdog_overflow_flag;
        sfr_rdata[`NVW_BIT_FULL_RANGE] = full_range_unlock;
      end
      `NVW_ADDR_AUX_CONTROL_TWO: begin
        sfr_rdata = auxiliary_control_two;
      end
      default: begin
        sfr_rdata = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // eeprom array and load path

  nvw_eeprom_array u_cells (
    .clk      (core_clk),
    .wr_en    (ee_wr_en),
    .wr_index (ee_wr_index),
    .wr_data  (ee_wr_data),
    .rd_index (ee_rd_index),
    .rd_data  (ee_rd_data)
  );

  // load answers two cycles later (80 ns), well inside the read time
  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ee_rd_pend   <= 1'b0;
      xdata_rdata  <= 8'h00;
      xdata_rvalid <= 1'b0;
    end else begin
      ee_rd_pend   <= idle && xdata_rd && is_eeprom_even(xdata_addr);
      xdata_rvalid <= ee_rd_pend;
      if (ee_rd_pend) begin
        xdata_rdata <= ee_rd_data;
      end
    end
  end

endmodule

`default_nettype wire

// ### sim/nvw_flash_model.sv
/* nvw_flash_model.sv: behavioural flash macro program port.
   assumes: one-cycle program strobe on clk; done answers after delay_cyc. */
`default_nettype none
module nvw_flash_model (
  // clock
  input  wire logic        clk,
  // program port
  input  wire logic        prog,
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  data,
  output logic             done,
  // scenario controls
  input  wire logic [7:0]  delay_cyc,
  input  wire logic        mute
);
  logic [7:0] mem [0:8191];
  int         cnt = 0;
  always @(posedge clk) begin
    done <= 1'b0;
    if (prog) begin
      // a stuck cell keeps its old byte
      if (!mute) begin
        mem[addr] <= data;
      end
      cnt <= delay_cyc;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt  <= 0;
      done <= !mute;
    end
  end
endmodule
`default_nettype wire

// ### sim/nvw_ctrl_monitor.sv
/* nvw_ctrl_monitor.sv: port assertions for the write controller.
   assumes: bound into nvw_ctrl; single core_clk domain. */
`default_nettype none
module nvw_ctrl_monitor #(
  parameter [19:0] EEPROM_WRITE_CYC = 20'd25000,
  parameter [19:0] TO3_CYC          = 20'd320000
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        xdata_wr,
  input wire logic        xdata_rd,
  input wire logic [15:0] xdata_addr,
  input wire logic        xdata_rvalid,
  input wire logic        cpu_wait,
  input wire logic        flash_prog,
  input wire logic [12:0] flash_prog_addr,
  input wire logic        flash_prog_done,
  input wire logic        code_wait,
  input wire logic        soft_reset_command,
  input wire logic        low_voltage_reset_off,
  input wire logic        power_on_reset_off
);
  localparam int EEP_END  = EEPROM_WRITE_CYC + 2;
  localparam int WAIT_MAX = TO3_CYC + 2;
  logic       we_flash;
  logic       we_eep;
  logic       unlock;
  logic [1:0] tsel;
  int         wait_cnt;
  // shadow of the enables so assertions need no internal probes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      we_flash <= 1'b0;
      we_eep   <= 1'b0;
      unlock   <= 1'b0;
      tsel     <= 2'b11;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= cpu_wait ? wait_cnt + 1 : 0;
      if (sfr_wr && sfr_addr == 8'hC9) begin
        we_flash <= sfr_wdata == 8'h47;
        we_eep   <= sfr_wdata == 8'hE2;
      end
      if (sfr_wr && sfr_addr == 8'h97 && sfr_wdata != 8'h56) begin
        unlock <= sfr_wdata == 8'h65;
      end
      if (sfr_wr && sfr_addr == 8'hF7) begin
        tsel <= sfr_wdata[2:1];
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_eep_store;
    xdata_wr && !cpu_wait && we_eep && xdata_addr[15:8] == 8'hEE && !xdata_addr[0];
  endsequence
  sequence s_eep_busy;
    cpu_wait [*8] ##[1:EEP_END] !cpu_wait;
  endsequence
  sequence s_eep_load;
    xdata_rd && !cpu_wait && xdata_addr[15:8] == 8'hEE && !xdata_addr[0];
  endsequence
////////////////////////////////////////////////////////////////////////////////
  property code_rd_ok;
    code_wait == 1'b0;
  endproperty
  a_code_no_wait: assert property (code_rd_ok) else $error("code read stalled");
  a_prog_from_store: assert property (flash_prog |-> $past(xdata_wr) && !$past(cpu_wait)
    && $past(we_flash) && $past(xdata_addr) <= 16'h1FEF
    && ($past(unlock) || $past(xdata_addr) >= 16'h1F00)) else $error("bad program strobe");
  a_prog_payload: assert property (flash_prog |-> {3'b000, flash_prog_addr} ==
    $past(xdata_addr)) else $error("program address differs");
  a_prog_stalls: assert property (flash_prog |-> cpu_wait) else $error("no stall");
  a_done_release: assert property (cpu_wait && flash_prog_done |=> !cpu_wait)
    else $error("stall outlives done");
  a_refused_store: assert property (xdata_wr && !cpu_wait && !we_flash && !we_eep
    |=> !cpu_wait && !flash_prog) else $error("disabled store acted");
  a_eeprom_stall: assert property (s_eep_store |=> s_eep_busy)
    else $error("eeprom stall length");
  a_eeprom_read: assert property (s_eep_load |-> ##2 xdata_rvalid)
    else $error("eeprom read late");
  a_odd_ignored: assert property (xdata_wr && !cpu_wait && xdata_addr[15:8] == 8'hEE
    && xdata_addr[0] |=> !cpu_wait) else $error("odd address stalled");
  a_flag_readback: assert property (sfr_addr == 8'hC9 |-> sfr_rdata[7] == we_flash
    && sfr_rdata[5] == we_eep && (we_flash || we_eep || !sfr_rdata[6]))
    else $error("enable readback");
  a_soft_reset: assert property (sfr_wr && sfr_addr == 8'h97 && sfr_wdata == 8'h56
    |=> soft_reset_command ##1 !soft_reset_command) else $error("soft reset pulse");
  a_power_down: assert property (sfr_wr && sfr_addr == 8'hE5 |=>
    low_voltage_reset_off == ($past(sfr_wdata) == 8'h37 || $past(sfr_wdata) == 8'h38)
    && power_on_reset_off == ($past(sfr_wdata) == 8'h37)) else $error("power down code");
  a_wait_bounded: assert property (tsel != 2'b00 |-> wait_cnt <= WAIT_MAX)
    else $error("stall not escaped");
endmodule
bind nvw_ctrl nvw_ctrl_monitor #(.EEPROM_WRITE_CYC(EEPROM_WRITE_CYC), .TO3_CYC(TO3_CYC)) u_mon (
  .core_clk(core_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr), .xdata_rd(xdata_rd),
  .xdata_addr(xdata_addr), .xdata_rvalid(xdata_rvalid), .cpu_wait(cpu_wait),
  .flash_prog(flash_prog), .flash_prog_addr(flash_prog_addr),
  .flash_prog_done(flash_prog_done), .code_wait(code_wait),
  .soft_reset_command(soft_reset_command), .low_voltage_reset_off(low_voltage_reset_off),
  .power_on_reset_off(power_on_reset_off));
`default_nettype wire

// ### sim/nvw_ctrl_tb.sv
/* nvw_ctrl_tb.sv: self-checking bench, the bench plays the cpu core.
   assumes: shortened write and timeout counts; flash macro is a model. */
`default_nettype none
module nvw_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst_n, sfr_wr, xdata_wr, xdata_rd, code_rd, mute;
  logic        xdata_rvalid, cpu_wait, fprog, fdone, code_wait, srst, volt_off, por_off;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, xdata_rdata, fdata, dly;
  logic [15:0] xdata_addr;
  logic [12:0] faddr;
  int          failures = 0;
  int          samples_checked = 0;
  nvw_ctrl #(.EEPROM_WRITE_CYC(20'd60), .TO1_CYC(20'd40), .TO2_CYC(20'd80), .TO3_CYC(20'd160))
  uut (.core_clk(core_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(1'b0),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr),
    .xdata_rd(xdata_rd), .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .xdata_rdata(xdata_rdata), .xdata_rvalid(xdata_rvalid), .cpu_wait(cpu_wait),
    .flash_prog(fprog), .flash_prog_addr(faddr), .flash_prog_data(fdata),
    .flash_prog_done(fdone), .code_rd(code_rd), .code_wait(code_wait),
    .soft_reset_command(srst), .low_voltage_reset_off(volt_off), .power_on_reset_off(por_off));
  nvw_flash_model fm (.clk(core_clk), .prog(fprog), .addr(faddr), .data(fdata),
    .done(fdone), .delay_cyc(dly), .mute(mute));
////////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, logic [7:0] m, logic [7:0] e, string w);
    @(negedge core_clk);
    sfr_addr = a;
    #1 check(w, e, sfr_rdata & m);
  endtask
  task automatic store(logic [15:0] a, logic [7:0] d, output int n);
    @(negedge core_clk);
    xdata_wr = 1'b1;
    xdata_addr = a;
    xdata_wdata = d;
    @(negedge core_clk);
    xdata_wr = 1'b0;
    n = 0;
    while (cpu_wait === 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic load(logic [15:0] a, logic [7:0] e, string w);
    @(negedge core_clk);
    xdata_rd = 1'b1;
    xdata_addr = a;
    @(negedge core_clk);
    xdata_rd = 1'b0;
    @(negedge core_clk);
    check(w, {8'h01, e}, {7'h00, xdata_rvalid, xdata_rdata});
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] pd [3] = '{8'h37, 8'h38, 8'h11};
    rreg(8'hC9, 8'hE0, 8'h00, "enable reset");
    rreg(8'hF7, 8'hFF, 8'h06, "aux two reset");
    rreg(8'h80, 8'hFF, 8'h00, "unmapped");
    wreg(8'hC9, 8'h47);
    rreg(8'hC9, 8'hE0, 8'h80, "flash enable");
    wreg(8'hC9, 8'hE2);
    rreg(8'hC9, 8'hE0, 8'h20, "eeprom enable");
    wreg(8'hC9, 8'h5A);
    rreg(8'hC9, 8'hE0, 8'h00, "other code");
    wreg(8'h97, 8'h65);
    rreg(8'h97, 8'h01, 8'h01, "unlock");
    wreg(8'h97, 8'h56);
    check("soft reset", 1, srst);
    rreg(8'h97, 8'h01, 8'h01, "unlock kept");
    wreg(8'h97, 8'h00);
    rreg(8'h97, 8'h01, 8'h00, "lock");
    for (int i = 0; i < 3; i++) begin
      wreg(8'hE5, pd[i]);
      check("power down", {i < 2, i == 0}, {volt_off, por_off});
    end
  endtask
  task automatic t_flash;
    int n;
    code_rd = 1'b1;
    #1 check("code wait", 0, code_wait);
    wreg(8'hC9, 8'h47);
    dly = 8'd3;
    store(16'h1F00, 8'h5A, n);
    check("flash byte", 8'h5A, fm.mem[13'h1F00]);
    check("flash stall", 1, n >= 3 && n <= 6);
    store(16'h0100, 8'hA3, n);
    check("locked store", 0, n);
    wreg(8'h97, 8'h65);
    dly = 8'd40;
    store(16'h0100, 8'hA3, n);
    check("unlocked byte", 8'hA3, fm.mem[13'h0100]);
    check("slow stall", 1, n >= 40 && n <= 43);
    store(16'h1FF0, 8'h11, n);
    check("above range", 0, n);
    wreg(8'hC9, 8'h00);
    store(16'h1F10, 8'h22, n);
    check("disabled store", 0, n);
  endtask
  task automatic t_eeprom;
    int n;
    wreg(8'hF7, 8'h04);
    wreg(8'hC9, 8'hE2);
    store(16'hEE04, 8'hA5, n);
    check("eeprom stall", 1, n >= 58 && n <= 62);
    load(16'hEE04, 8'hA5, "eeprom read");
    store(16'hEE05, 8'h33, n);
    check("odd address", 0, n);
    store(16'h1F00, 8'h44, n);
    check("flash not enabled", 0, n);
    wreg(8'hF7, 8'h02);
    store(16'hEE04, 8'h3C, n);
    check("eeprom timeout", 1, n >= 38 && n <= 42);
    rreg(8'hC9, 8'hE0, 8'h60, "eeprom flag");
    load(16'hEE04, 8'hA5, "cell kept");
    wreg(8'hC9, 8'h00);
    rreg(8'hC9, 8'hE0, 8'h00, "flag cleared");
  endtask
  task automatic t_timeout;
    int n;
    int lim;
    mute = 1'b1;
    for (int s = 1; s < 4; s++) begin
      lim = (s == 3) ? 160 : 40 * s;
      wreg(8'hF7, {5'h00, s[1:0], 1'b0});
      wreg(8'hC9, 8'h47);
      store(16'h1F20, 8'h77, n);
      check("flash timeout", 1, n >= lim - 2 && n <= lim + 2);
      rreg(8'hC9, 8'hE0, 8'hC0, "timeout flag");
      wreg(8'hC9, 8'h00);
      rreg(8'hC9, 8'hE0, 8'h00, "flag cleared");
    end
    // with the escape off only a reset frees the core
    wreg(8'hF7, 8'h00);
    wreg(8'hC9, 8'h47);
    store(16'h1F20, 8'h77, n);
    check("no escape", 1000, n);
    do_reset;
    check("wait after reset", 0, cpu_wait);
    mute = 1'b0;
  endtask
  task automatic conclude;
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    failures++;
    conclude;
  end
  initial begin
    {sfr_wr, xdata_wr, xdata_rd, code_rd, mute} = '0;
    {sfr_addr, sfr_wdata, xdata_wdata, xdata_addr} = '0;
    dly = 8'd3;
    do_reset;
    t_regs;
    t_flash;
    t_eeprom;
    t_timeout;
    conclude;
  end
endmodule
`default_nettype wire
